// >>> src/bpg_fifo.sv
// Small flop FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/10ps
module bpg_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	wire push = i_in_valid & o_in_ready;
	wire pop = o_out_valid & i_out_ready;

	assign o_in_ready = count != CNT_FULL;
	assign o_out_valid = count != '0;
	assign o_out_data = mem[rd_ptr];

	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : PW'(wr_ptr + 1'b1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : PW'(rd_ptr + 1'b1);
			end
			count <= CW'(count + CW'(push) - CW'(pop));
		end
	end
endmodule

// >>> src/bpg_pkg.sv
// Constants shared by the pattern generator and checker.
// Assumes an 8-bit host port and one core clock.
package bpg_pkg;
	localparam logic [7:0] A_CTRL1 = 8'he0;
	localparam logic [7:0] A_CTRL2 = 8'he1;
	localparam logic [7:0] A_STATUS = 8'h26;
	localparam logic [7:0] A_MASK = 8'h27;
	localparam logic [7:0] A_AWC = 8'hdb;
	localparam logic [7:0] A_PAT0 = 8'he4;
	localparam logic [7:0] A_PAT1 = 8'he5;
	localparam logic [7:0] A_PAT2 = 8'he6;
	localparam logic [7:0] A_PAT3 = 8'he7;
	localparam logic [7:0] A_IFC = 8'hea;
	localparam logic [7:0] A_INFO = 8'heb;
	localparam logic [7:0] A_BCNT0 = 8'hec;
	localparam logic [7:0] A_BCNT1 = 8'hed;
	localparam logic [7:0] A_BCNT2 = 8'hee;
	localparam logic [7:0] A_BCNT3 = 8'hef;
	localparam logic [7:0] A_ECNT0 = 8'hf0;
	localparam logic [7:0] A_ECNT1 = 8'hf1;
	localparam logic [7:0] A_ECNT2 = 8'hf2;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int C1_FORCE_A = 0;
	localparam int C1_LC = 1;
	localparam int C1_PS_LSB = 2;
	localparam int C1_RX_INVERT = 5;
	localparam int C1_TX_INVERT = 6;
	localparam int C1_TC = 7;
	localparam int IFC_EN = 0;
	localparam int IFC_DIR = 1;
	localparam int IFC_RX_FRAMING_BIT_USE = 2;
	localparam int IFC_TX_FRAMING_BIT_USE = 3;
	localparam int ST_SYNC = 0;
	localparam int ST_LOS = 1;
	localparam int ST_ECO = 4;
	localparam int ST_BCO = 5;
	localparam int ST_BED = 6;
	localparam logic [4:0] SYNC_MATCH_LAST = 5'h1f;
	localparam logic [5:0] LOSS_WIN_LAST = 6'h3f;
	localparam logic [2:0] LOSS_ERRS_LAST = 3'h5;
	localparam logic [5:0] DALY_LAST = 6'h36;
	localparam logic [19:0] LFSR_SEED = 20'hfffff;
	localparam int FIFO_WIDTH = 1;
	localparam int FIFO_DEPTH = 8;
	typedef enum logic [2:0] {
		PAT_P7, PAT_P11, PAT_P15, PAT_QRSS, PAT_REP, PAT_ALT, PAT_DALY, PAT_P9
	} bpg_pat_t;
	typedef enum logic {RX_SEARCH, RX_SYNC} bpg_rx_state_t;
endpackage

// >>> src/bpg_top.sv
// Bit-error-rate pattern generator and receive checker for one port.
// Assumes the framer streams run on i_core_clk and give one-cycle bit strobes.
`timescale 1ns/10ps
module bpg_top (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_alert,
	input wire logic i_t1_mode,
	input wire logic i_net_tx_strobe,
	input wire logic i_bp_tx_strobe,
	input wire logic i_tx_slot_select,
	input wire logic i_tx_fbit,
	output logic o_tx_bit,
	output logic o_net_tx_insert,
	output logic o_bp_tx_insert,
	input wire logic i_net_rx_strobe,
	input wire logic i_net_rx_bit,
	input wire logic i_bp_rx_strobe,
	input wire logic i_bp_rx_bit,
	input wire logic i_rx_slot_select,
	input wire logic i_rx_fbit
);
	////////////////////////////////////////////////////////////////////////
	// Pattern functions
	function automatic logic prbs_fb(input bpg_pkg::bpg_pat_t p, input logic [19:0] h);
		case (p)
			bpg_pkg::PAT_P7: prbs_fb = h[6] ^ h[5];
			bpg_pkg::PAT_P11: prbs_fb = h[10] ^ h[8];
			bpg_pkg::PAT_P15: prbs_fb = h[14] ^ h[13];
			bpg_pkg::PAT_P9: prbs_fb = h[8] ^ h[4];
			bpg_pkg::PAT_QRSS: prbs_fb = h[19] ^ h[16];
			default: prbs_fb = 1'b0;
		endcase
	endfunction

	// Octet content is arbitrary filler with the right period
	function automatic logic [7:0] daly_octet(input logic [5:0] i);
		daly_octet = {i, 2'b01} ^ 8'h5a;
	endfunction

	// State word: {pos[4:0], cnt[7:0], wsel, idx[5:0]}
	function automatic logic pat_bit(input bpg_pkg::bpg_pat_t p, input logic [19:0] s,
			input logic [31:0] pat);
		logic [7:0] oct;
		oct = daly_octet(s[5:0]);
		case (p)
			bpg_pkg::PAT_REP: pat_bit = pat[s[19:15]];
			bpg_pkg::PAT_ALT: pat_bit = pat[{s[6], s[18:15]}];
			bpg_pkg::PAT_DALY: pat_bit = oct[s[17:15]];
			default: pat_bit = 1'b0;
		endcase
	endfunction

	function automatic logic [19:0] pat_step(input bpg_pkg::bpg_pat_t p, input logic [19:0] s,
			input logic [4:0] len_last, input logic [7:0] awc);
		logic [4:0] pos;
		logic [7:0] cnt;
		logic wsel;
		logic [5:0] idx;
		{pos, cnt, wsel, idx} = s;
		case (p)
			bpg_pkg::PAT_REP: pos = (pos == len_last) ? 5'h00 : 5'(pos + 5'h01);
			bpg_pkg::PAT_ALT: begin
				if (pos[3:0] == 4'hf) begin
					pos = 5'h00;
					if (cnt == awc) begin
						cnt = 8'h00;
						wsel = ~wsel;
					end else begin
						cnt = 8'(cnt + 8'h01);
					end
				end else begin
					pos = 5'(pos + 5'h01);
				end
			end
			bpg_pkg::PAT_DALY: begin
				if (pos[2:0] == 3'h7) begin
					pos = 5'h00;
					idx = (idx == bpg_pkg::DALY_LAST) ? 6'h00 : 6'(idx + 6'h01);
				end else begin
					pos = 5'(pos + 5'h01);
				end
			end
			default: pos = 5'h00;
		endcase
		pat_step = {pos, cnt, wsel, idx};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] ctrl1;
	logic [7:0] ctrl1_prev;
	logic [7:0] ctrl2;
	logic [7:0] awc;
	logic [31:0] pattern;
	logic [7:0] ifc;
	logic [7:0] mask;
	logic [6:0] status;
	logic [31:0] bit_cnt;
	logic [23:0] err_cnt;
	logic [31:0] bit_count_hold;
	logic [23:0] error_count_hold;

	wire wr_c1 = i_wr & (i_addr == bpg_pkg::A_CTRL1);
	wire rd_status = i_rd & (i_addr == bpg_pkg::A_STATUS);
	wire [7:0] rise = ctrl1 & ~ctrl1_prev;
	wire force_a_p = rise[bpg_pkg::C1_FORCE_A];
	wire load_p = rise[bpg_pkg::C1_LC];
	wire tload_p = rise[bpg_pkg::C1_TC];
	wire enabled = ifc[bpg_pkg::IFC_EN];
	wire dir_bp = ifc[bpg_pkg::IFC_DIR];
	wire bpg_pkg::bpg_pat_t pmode = bpg_pkg::bpg_pat_t'(ctrl1[bpg_pkg::C1_PS_LSB +: 3]);
	wire is_prbs = (pmode != bpg_pkg::PAT_REP) & (pmode != bpg_pkg::PAT_ALT) & (pmode != bpg_pkg::PAT_DALY);
	wire [4:0] len_last = {1'b1, ctrl2[3:0]};

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			ctrl1 <= bpg_pkg::REG_RESET;
			ctrl1_prev <= bpg_pkg::REG_RESET;
			ctrl2 <= bpg_pkg::REG_RESET;
			awc <= bpg_pkg::REG_RESET;
			pattern <= '0;
			ifc <= bpg_pkg::REG_RESET;
			mask <= bpg_pkg::REG_RESET;
		end else begin
			ctrl1_prev <= ctrl1;
			if (wr_c1) ctrl1 <= i_wdata;
			if (i_wr & (i_addr == bpg_pkg::A_CTRL2)) ctrl2 <= i_wdata;
			if (i_wr & (i_addr == bpg_pkg::A_AWC)) awc <= i_wdata;
			if (i_wr & (i_addr == bpg_pkg::A_PAT0)) pattern[7:0] <= i_wdata;
			if (i_wr & (i_addr == bpg_pkg::A_PAT1)) pattern[15:8] <= i_wdata;
			if (i_wr & (i_addr == bpg_pkg::A_PAT2)) pattern[23:16] <= i_wdata;
			if (i_wr & (i_addr == bpg_pkg::A_PAT3)) pattern[31:24] <= i_wdata;
			if (i_wr & (i_addr == bpg_pkg::A_IFC)) ifc <= i_wdata;
			if (i_wr & (i_addr == bpg_pkg::A_MASK)) mask <= i_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Generator feeding the FIFO
	logic [19:0] g_lfsr;
	logic [19:0] g_st;
	logic g_ready;
	logic f_valid;
	logic [0:0] f_data;
	wire g_fb = prbs_fb(pmode, g_lfsr);
	wire g_qrss_force = (pmode == bpg_pkg::PAT_QRSS) & (g_lfsr[13:0] == 14'h0000);
	wire g_raw = is_prbs ? (g_fb | g_qrss_force) : pat_bit(pmode, g_st, pattern);
	wire g_bit = g_raw ^ ctrl1[bpg_pkg::C1_TX_INVERT];
	wire g_push = enabled & g_ready;

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			g_lfsr <= bpg_pkg::LFSR_SEED;
			g_st <= '0;
		end else if (tload_p) begin
			g_lfsr <= bpg_pkg::LFSR_SEED;
			g_st <= '0;
		end else if (g_push) begin
			g_lfsr <= {g_lfsr[18:0], g_fb};
			g_st <= pat_step(pmode, g_st, len_last, awc);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit slot insertion
	wire tx_strobe = dir_bp ? i_bp_tx_strobe : i_net_tx_strobe;
	wire tx_fbit_ok = i_tx_fbit & i_t1_mode & ifc[bpg_pkg::IFC_TX_FRAMING_BIT_USE];
	wire tx_take = enabled & tx_strobe & ((i_tx_slot_select & ~i_tx_fbit) | tx_fbit_ok);
	wire tx_pop = tx_take & f_valid;

	bpg_fifo #(
		.WIDTH(bpg_pkg::FIFO_WIDTH),
		.DEPTH(bpg_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.i_in_valid(enabled),
		.o_in_ready(g_ready),
		.i_in_data(g_bit),
		.o_out_valid(f_valid),
		.i_out_ready(tx_take),
		.o_out_data(f_data)
	);

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_tx_bit <= 1'b0;
			o_net_tx_insert <= 1'b0;
			o_bp_tx_insert <= 1'b0;
		end else begin
			if (tx_pop) o_tx_bit <= f_data[0];
			o_net_tx_insert <= tx_pop & ~dir_bp;
			o_bp_tx_insert <= tx_pop & dir_bp;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive checker
	bpg_pkg::bpg_rx_state_t rx_state;
	logic [19:0] hist;
	logic [19:0] r_st;
	logic [4:0] match_cnt;
	logic [5:0] win_cnt;
	logic [2:0] win_errs;
	wire rx_strobe = dir_bp ? i_bp_rx_strobe : i_net_rx_strobe;
	wire rx_raw = dir_bp ? i_bp_rx_bit : i_net_rx_bit;
	wire rx_fbit_ok = i_rx_fbit & i_t1_mode & ifc[bpg_pkg::IFC_RX_FRAMING_BIT_USE];
	wire rx_take = enabled & rx_strobe & ((i_rx_slot_select & ~i_rx_fbit) | rx_fbit_ok);
	wire rx_bit = rx_raw ^ ctrl1[bpg_pkg::C1_RX_INVERT];
	wire r_qrss_ok = (pmode == bpg_pkg::PAT_QRSS) & (hist[13:0] == 14'h0000) & rx_bit;
	wire r_exp = is_prbs ? prbs_fb(pmode, hist) : pat_bit(pmode, r_st, pattern);
	wire mismatch = rx_take & (rx_bit != r_exp) & ~r_qrss_ok;
	wire in_sync = rx_state == bpg_pkg::RX_SYNC;
	wire [19:0] r_next = pat_step(pmode, r_st, len_last, awc);
	wire gain_sync = ~in_sync & rx_take & ~mismatch & (match_cnt == bpg_pkg::SYNC_MATCH_LAST);
	wire lose_sync = in_sync & mismatch & (win_errs == bpg_pkg::LOSS_ERRS_LAST);
	wire enter_search = force_a_p | lose_sync;
	wire bit_err = in_sync & mismatch;
	wire count_bit = in_sync & rx_take;
	wire bit_ovf = count_bit & (&bit_cnt);
	wire err_ovf = bit_err & (&err_cnt);

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			rx_state <= bpg_pkg::RX_SEARCH;
			hist <= '0;
			r_st <= '0;
			match_cnt <= '0;
		end else begin
			// In sync the replica runs on its own prediction, so one bad bit counts once
			if (rx_take) hist <= {hist[18:0], (in_sync | r_qrss_ok) ? r_exp : rx_bit};
			// While searching, a mismatch slips the replica one extra bit
			if (rx_take) r_st <= (mismatch & ~in_sync) ? pat_step(pmode, r_next, len_last, awc) : r_next;
			if (enter_search) begin
				rx_state <= bpg_pkg::RX_SEARCH;
				match_cnt <= '0;
			end else if (gain_sync) begin
				rx_state <= bpg_pkg::RX_SYNC;
			end else if (~in_sync & rx_take) begin
				match_cnt <= mismatch ? 5'h00 : 5'(match_cnt + 5'h01);
			end
		end
	end

	// Loss of sync: too many errors inside one window of bits
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			win_cnt <= '0;
			win_errs <= '0;
		end else if (~in_sync | (rx_take & (win_cnt == bpg_pkg::LOSS_WIN_LAST))) begin
			win_cnt <= '0;
			win_errs <= '0;
		end else if (rx_take) begin
			win_cnt <= 6'(win_cnt + 6'h01);
			win_errs <= 3'(win_errs + 3'(mismatch));
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			bit_cnt <= '0;
			err_cnt <= '0;
			bit_count_hold <= '0;
			error_count_hold <= '0;
		end else if (load_p) begin
			bit_count_hold <= bit_cnt;
			error_count_hold <= err_cnt;
			bit_cnt <= '0;
			err_cnt <= '0;
		end else begin
			bit_cnt <= 32'(bit_cnt + 32'(count_bit));
			err_cnt <= 24'(err_cnt + 24'(bit_err));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status, alert and read-back
	wire [6:0] events = {bit_err, bit_ovf, err_ovf, 2'b00,
		enter_search & (in_sync | ~status[bpg_pkg::ST_LOS]), gain_sync | lose_sync};

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			status <= '0;
		end else begin
			status <= (rd_status ? 7'h00 : status) | events;
		end
	end

	assign o_alert = |(status & mask[6:0]);

	wire [7:0] rd_mux =
		(i_addr == bpg_pkg::A_CTRL1) ? ctrl1 :
		(i_addr == bpg_pkg::A_CTRL2) ? ctrl2 :
		(i_addr == bpg_pkg::A_STATUS) ? {1'b0, status} :
		(i_addr == bpg_pkg::A_MASK) ? mask :
		(i_addr == bpg_pkg::A_AWC) ? awc :
		(i_addr == bpg_pkg::A_PAT0) ? pattern[7:0] :
		(i_addr == bpg_pkg::A_PAT1) ? pattern[15:8] :
		(i_addr == bpg_pkg::A_PAT2) ? pattern[23:16] :
		(i_addr == bpg_pkg::A_PAT3) ? pattern[31:24] :
		(i_addr == bpg_pkg::A_IFC) ? ifc :
		(i_addr == bpg_pkg::A_INFO) ? {7'h00, in_sync} :
		(i_addr == bpg_pkg::A_BCNT0) ? bit_count_hold[7:0] :
		(i_addr == bpg_pkg::A_BCNT1) ? bit_count_hold[15:8] :
		(i_addr == bpg_pkg::A_BCNT2) ? bit_count_hold[23:16] :
		(i_addr == bpg_pkg::A_BCNT3) ? bit_count_hold[31:24] :
		(i_addr == bpg_pkg::A_ECNT0) ? error_count_hold[7:0] :
		(i_addr == bpg_pkg::A_ECNT1) ? error_count_hold[15:8] :
		(i_addr == bpg_pkg::A_ECNT2) ? error_count_hold[23:16] :
		8'h00;

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= rd_mux;
		end
	end
endmodule

// >>> testbench/bpg_framer_model.sv
// Framer stand-in: offers transmit slots and loops each inserted bit back.
// Assumes one core clock; controls come from the bench.
`timescale 1ns/10ps
module bpg_framer_model (
	input wire logic i_core_clk,
	input wire logic i_run,
	input wire logic i_slow,
	input wire logic i_dir,
	input wire logic i_inv,
	input wire logic i_flip,
	input wire logic i_tx_bit,
	input wire logic i_net_tx_insert,
	input wire logic i_bp_tx_insert,
	output logic o_net_tx_strobe,
	output logic o_bp_tx_strobe,
	output logic o_net_rx_strobe,
	output logic o_bp_rx_strobe,
	output logic o_net_rx_bit,
	output logic o_bp_rx_bit,
	output int o_sent
);
	logic [1:0] div;
	logic flip_s, flip_done, ins, b;
	assign ins = i_net_tx_insert || i_bp_tx_insert;
	// A toggle of i_flip corrupts exactly one looped bit
	assign b = i_tx_bit ^ i_inv ^ (flip_s != flip_done);
	initial begin
		{o_net_tx_strobe, o_bp_tx_strobe, o_net_rx_strobe, o_bp_rx_strobe, o_net_rx_bit, o_bp_rx_bit} = 6'h00;
		{div, flip_s, flip_done} = 4'h0;
		o_sent = 0;
	end
	always @(posedge i_core_clk) flip_s <= i_flip;
	always @(negedge i_core_clk) begin
		div <= div + 2'h1;
		o_net_tx_strobe <= i_run && !i_dir && (!i_slow || div == 2'h0);
		o_bp_tx_strobe <= i_run && i_dir && (!i_slow || div == 2'h0);
		o_net_rx_strobe <= ins && !i_dir;
		o_bp_rx_strobe <= ins && i_dir;
		// Outside a bit slot the data line keeps toggling
		o_net_rx_bit <= ins ? b : ~o_net_rx_bit;
		o_bp_rx_bit <= ins ? b : ~o_bp_rx_bit;
		if (ins) begin
			o_sent <= o_sent + 1;
			flip_done <= flip_s;
		end
	end
endmodule

// >>> testbench/bpg_top_properties.sv
// Concurrent checks on the host and framer ports of bpg_top.
// Assumes it is bound to bpg_top and sees only its ports.
`timescale 1ns/10ps
module bpg_top_checker (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_alert,
	input wire logic i_t1_mode,
	input wire logic i_net_tx_strobe,
	input wire logic i_bp_tx_strobe,
	input wire logic i_tx_slot_select,
	input wire logic i_tx_fbit,
	input wire logic o_net_tx_insert,
	input wire logic o_bp_tx_insert
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_reset);
	wire tx_sel = (i_tx_slot_select && !i_tx_fbit) || (i_tx_fbit && i_t1_mode);
	wire net_take = i_net_tx_strobe && tx_sel;
	wire bp_take = i_bp_tx_strobe && tx_sel;
	////////////////////////////////////////////////////////////
	sequence s_wr(logic [7:0] a);
		i_wr && i_addr == a;
	endsequence
	sequence s_rd(logic [7:0] a);
		i_rd && !i_wr && i_addr == a;
	endsequence
	property p_net_map;
		o_net_tx_insert |-> $past(net_take);
	endproperty
	property p_bp_map;
		o_bp_tx_insert |-> $past(bp_take);
	endproperty
	property p_one_dir;
		!(o_net_tx_insert && o_bp_tx_insert);
	endproperty
	property p_ctrl_back;
		s_wr(8'he0) ##1 s_rd(8'he0) |=> o_rdata == $past(i_wdata, 2);
	endproperty
	property p_disabled;
		s_wr(8'hea) ##0 !i_wdata[0] ##1 !i_wr |=> !o_net_tx_insert && !o_bp_tx_insert;
	endproperty
	property p_mask_off;
		s_wr(8'h27) ##0 i_wdata == 8'h00 |=> !o_alert;
	endproperty
	property p_status_rsv;
		s_rd(8'h26) |=> o_rdata[7] == 1'b0 && o_rdata[3:2] == 2'h0;
	endproperty
	property p_rdata_hold;
		!i_rd |=> $stable(o_rdata);
	endproperty
	a_net_map: assert property (p_net_map) else $error("net insert without a taken slot");
	a_bp_map: assert property (p_bp_map) else $error("backplane insert without a taken slot");
	a_one_dir: assert property (p_one_dir) else $error("both directions inserted at once");
	a_ctrl_back: assert property (p_ctrl_back) else $error("control readback differs");
	a_disabled: assert property (p_disabled) else $error("insert while disabled");
	a_mask_off: assert property (p_mask_off) else $error("alert with all masked");
	a_status_rsv: assert property (p_status_rsv) else $error("reserved status bits set");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
endmodule
bind bpg_top bpg_top_checker u_bpg_chk (.i_core_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_alert,
	.i_t1_mode, .i_net_tx_strobe, .i_bp_tx_strobe, .i_tx_slot_select, .i_tx_fbit, .o_net_tx_insert, .o_bp_tx_insert);

// >>> testbench/test_bpg_top.sv
// Self-checking bench for bpg_top with a looped-back framer model.
// Assumes the model returns every inserted bit one cycle later.
`timescale 1ns/10ps
module test_bpg_top;
	typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} bpg_row_t;
	logic i_core_clk, i_reset, i_wr, i_rd, i_tx_slot_select, i_rx_slot_select;
	logic [7:0] i_addr, i_wdata, o_rdata, base, d;
	logic o_alert, o_tx_bit, o_net_tx_insert, o_bp_tx_insert;
	logic net_txs, bp_txs, net_rxs, bp_rxs, net_rxb, bp_rxb, run, slow, dir, inv, flip;
	logic [31:0] v;
	int miscompares, n_compared, sent, n0;
	bpg_row_t rows[10] = '{'{8'he4, 8'h5a, 8'h5a}, '{8'he5, 8'hc3, 8'hc3}, '{8'he6, 8'h96, 8'h96},
		'{8'he7, 8'h3c, 8'h3c}, '{8'he1, 8'h0f, 8'h0f}, '{8'hdb, 8'h03, 8'h03}, '{8'h27, 8'h41, 8'h41},
		'{8'hea, 8'h01, 8'h01}, '{8'h00, 8'hff, 8'h00}, '{8'hf0, 8'hff, 8'h00}};
	bpg_top dut (.i_core_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_alert, .i_t1_mode(1'b0),
		.i_net_tx_strobe(net_txs), .i_bp_tx_strobe(bp_txs), .i_tx_slot_select, .i_tx_fbit(1'b0), .o_tx_bit,
		.o_net_tx_insert, .o_bp_tx_insert, .i_net_rx_strobe(net_rxs), .i_net_rx_bit(net_rxb),
		.i_bp_rx_strobe(bp_rxs), .i_bp_rx_bit(bp_rxb), .i_rx_slot_select, .i_rx_fbit(1'b0));
	bpg_framer_model u_framer (.i_core_clk, .i_run(run), .i_slow(slow), .i_dir(dir), .i_inv(inv), .i_flip(flip),
		.i_tx_bit(o_tx_bit), .i_net_tx_insert(o_net_tx_insert), .i_bp_tx_insert(o_bp_tx_insert),
		.o_net_tx_strobe(net_txs), .o_bp_tx_strobe(bp_txs), .o_net_rx_strobe(net_rxs), .o_bp_rx_strobe(bp_rxs),
		.o_net_rx_bit(net_rxb), .o_bp_rx_bit(bp_rxb), .o_sent(sent));
	////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		i_wr = 1'b1;
		i_addr = a;
		i_wdata = w;
		@(negedge i_core_clk);
		i_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		i_rd = 1'b1;
		i_addr = a;
		@(negedge i_core_clk);
		i_rd = 1'b0;
		d = o_rdata;
	endtask
	task automatic rd32(input logic [7:0] a);
		for (int k = 0; k < 4; k++) begin
			rd(a + 8'(k));
			v[8*k +: 8] = d;
		end
	endtask
	task automatic pulse(input logic [7:0] b);
		wr(8'he0, base | b);
		wr(8'he0, base);
	endtask
	task automatic wait_sync(input logic e);
		d = 8'h00;
		for (int k = 0; k < 60 && !(e && d[0] === 1'b1); k++) begin
			repeat (40) @(negedge i_core_clk);
			rd(8'heb);
		end
	endtask
	task automatic tally_and_finish;
		$display("Counts: compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	initial begin
		repeat (80000) @(posedge i_core_clk);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		{i_reset, i_wr, i_rd, run, slow, dir, inv, flip} = 8'h80;
		{i_addr, i_wdata, base} = 24'h000000;
		{i_tx_slot_select, i_rx_slot_select} = 2'h3;
		repeat (16) @(negedge i_core_clk);
		i_reset = 1'b0;
		rd(8'he0);
		chk("control reset", d, 8'h00);
		rd(8'h26);
		chk("status reset", d, 8'h00);
		foreach (rows[r]) begin
			wr(rows[r].a, rows[r].w);
			rd(rows[r].a);
			chk("register readback", d, rows[r].e);
		end
		run = 1'b1;
		for (int p = 0; p < 8; p++) begin
			base = 8'(p << 2);
			pulse(8'h80);
			pulse(8'h01);
			rd(8'he0);
			chk("pattern select", d, base);
			wait_sync(1'b1);
			chk("sync per pattern", d[0], 1'b1);
		end
		chk("alert on sync", o_alert, 1'b1);
		wr(8'h27, 8'h00);
		chk("alert masked", o_alert, 1'b0);
		rd(8'h26);
		chk("sync event", d[0], 1'b1);
		base = 8'h00;
		pulse(8'h01);
		wait_sync(1'b1);
		rd(8'h26);
		chk("search restarted", d[1], 1'b1);
		// Counts: stop traffic around each load so no bit is in flight
		run = 1'b0;
		repeat (10) @(negedge i_core_clk);
		pulse(8'h02);
		n0 = sent;
		slow = 1'b1;
		run = 1'b1;
		repeat (200) @(negedge i_core_clk);
		flip = 1'b1;
		repeat (200) @(negedge i_core_clk);
		run = 1'b0;
		repeat (10) @(negedge i_core_clk);
		pulse(8'h02);
		rd32(8'hec);
		chk("bit count", v, 32'(sent - n0));
		rd32(8'hf0);
		chk("error count", v[23:0], 24'h000001);
		rd(8'h26);
		chk("bit error event", d[6], 1'b1);
		slow = 1'b0;
		run = 1'b1;
		inv = 1'b1;
		base = 8'h20;
		pulse(8'h01);
		wait_sync(1'b1);
		chk("rx invert sync", d[0], 1'b1);
		base = 8'h40;
		pulse(8'h01);
		wait_sync(1'b1);
		chk("tx invert sync", d[0], 1'b1);
		base = 8'h00;
		pulse(8'h01);
		wait_sync(1'b0);
		chk("inverted data no sync", d[0], 1'b0);
		inv = 1'b0;
		dir = 1'b1;
		wr(8'hea, 8'h03);
		pulse(8'h01);
		wait_sync(1'b1);
		chk("backplane sync", d[0], 1'b1);
		i_tx_slot_select = 1'b0;
		repeat (3) @(negedge i_core_clk);
		n0 = sent;
		repeat (50) @(negedge i_core_clk);
		chk("unselected slots", sent, n0);
		i_tx_slot_select = 1'b1;
		wr(8'hea, 8'h02);
		repeat (3) @(negedge i_core_clk);
		n0 = sent;
		repeat (50) @(negedge i_core_clk);
		chk("disabled block", sent, n0);
		tally_and_finish();
	end
endmodule
